/* File: gpcp_pkg.sv */
// How it works
// - A masked change on any pin of a group sets that group's flag.
// - Group request is raised only with flag, group enable and global enable.
// - Entering the group's service routine clears its flag.
// - Writing one to a flag bit clears it; writing zero keeps it.
// - A pin's change counts only if its mask bit and group enable are set.
// - One pin's direction, value or pull-up changes without touching others.
// - Each port has read/write value and direction, and a read-only input.
// - Writing one to an input sample bit inverts that pin's output value.
// - The global pull-up disable turns every pull-up off.
// - Direction one makes the pin an output, zero an input.
// - Pull-up is on only for an input with value one and pull-ups allowed.
// - An output pin is driven to its output value bit.
// - Reset tri-states every pin at once, without needing a clock.
// - Alternate functions on some pins leave the other pins unaffected.
// - Pins are latched on the falling clock, then registered on the rising.
// - Any enabled change in any group, the top one included, flags it.
package gpcp_pkg;
	localparam int         GRP_W         = 8;
	localparam int         NGRP_MAX      = 4;
	localparam logic [7:0] IDX_PORT_BASE = 8'h20;
	localparam logic [7:0] IDX_IN        = 8'h00;
	localparam logic [7:0] IDX_DIR       = 8'h01;
	localparam logic [7:0] IDX_OUT       = 8'h02;
	localparam logic [7:0] IDX_MCU       = 8'h35;
	localparam logic [7:0] IDX_GFLAG     = 8'h3b;
	localparam logic [7:0] IDX_GEN       = 8'h68;
	localparam logic [7:0] IDX_MASK [NGRP_MAX] = '{8'h6b, 8'h6c, 8'h6d, 8'h73};
	localparam int         PUD_BIT       = 4;
	localparam logic [7:0] RST_DIR       = 8'h00;
	localparam logic [7:0] RST_OUT       = 8'h00;
	localparam logic [7:0] RST_MASK      = 8'h00;
	localparam logic       RST_PUD       = 1'b0;
	localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
	localparam logic       HRESP_OKAY    = 1'b0;

	function automatic logic [7:0] gpcp_port_idx(int g, logic [7:0] k);
		return 8'(IDX_PORT_BASE + 8'(3 * g) + k);
	endfunction : gpcp_port_idx
endpackage : gpcp_pkg

/* File: gpcp_smp_if.sv */
`timescale 1ns/1ns
interface gpcp_smp_if #(parameter int W = 32);
	logic [W-1:0] smp;
	logic [W-1:0] chg;
	modport src (output smp, output chg);
	modport dst (input smp, input chg);
endinterface : gpcp_smp_if

/* File: gpcp_sync.sv */
`timescale 1ns/1ns
module gpcp_sync #(
	parameter int W = 32
) (
	// Clock, reset and clock enable.
	input logic         clk,
	input logic         reset_n,
	input logic         ce,
	// Raw pins and synchronised samples.
	input logic [W-1:0] pin_in,
	gpcp_smp_if.src     s
);
	logic [W-1:0] lat;
	logic [W-1:0] prev;

	// The latch closes on the falling edge, so a pin edge shows up after
	// half to one and a half clocks.
	always_ff @(negedge clk or negedge reset_n) begin
		if (!reset_n)
			lat <= '0;
		else if (ce)
			lat <= pin_in;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s.smp <= '0;
			prev  <= '0;
		end else if (ce) begin
			s.smp <= lat;
			prev  <= s.smp;
		end
	end

	assign s.chg = s.smp ^ prev;
endmodule : gpcp_sync

/* File: gpcp_port.sv */
// Added by the designer: the AHB-Lite interface to the registers.
`timescale 1ns/1ns
module gpcp_port
	import gpcp_pkg::*;
#(
	parameter int NGRP = 4
) (
	// Clock, reset and clock enable.
	input  logic                  clk,
	input  logic                  reset_n,
	input  logic                  ce,
	// AHB-Lite slave.
	input  logic                  hsel,
	input  logic [31:0]           haddr,
	input  logic [1:0]            htrans,
	input  logic                  hwrite,
	input  logic [2:0]            hsize,
	input  logic [31:0]           hwdata,
	input  logic                  hready,
	output logic                  hreadyout,
	output logic                  hresp,
	output logic [31:0]           hrdata,
	// Processor interrupt hand-shake.
	input  logic                  global_irq_enable,
	input  logic [NGRP-1:0]       isr_enter,
	output logic [NGRP-1:0]       irq_request,
	// Alternate function overrides.
	input  logic [NGRP*GRP_W-1:0] alt_en,
	input  logic [NGRP*GRP_W-1:0] alt_out,
	input  logic [NGRP*GRP_W-1:0] alt_oe,
	// Pins.
	input  logic [NGRP*GRP_W-1:0] pin_in,
	output logic [NGRP*GRP_W-1:0] pin_out,
	output logic [NGRP*GRP_W-1:0] pin_oe,
	output logic [NGRP*GRP_W-1:0] pin_pullup
);
	localparam int NP = NGRP * GRP_W;

	generate
		if (NGRP < 1 || NGRP > NGRP_MAX) begin : g_bad
			$error("gpcp_port: NGRP must be 1 to 4");
		end
	endgenerate

	logic [NP-1:0]   dir;
	logic [NP-1:0]   outv;
	logic [NP-1:0]   mask;
	logic [NGRP-1:0] gen;
	logic [NGRP-1:0] gflag;
	logic [NGRP-1:0] gset;
	logic [NGRP-1:0] gclr;
	logic            global_pullup_disable;
	logic            wr_pend;
	logic [7:0]      wr_idx;
	logic            rd_wait;
	logic [7:0]      rd_idx;
	logic [31:0]     rdata;
	logic            acc;
	logic            idx_ok;
	logic            wr_do;

	gpcp_smp_if #(.W(NP)) smp_bus ();

	gpcp_sync #(.W(NP)) u_sync (
		.clk     (clk),
		.reset_n (reset_n),
		.ce      (ce),
		.pin_in  (pin_in),
		.s       (smp_bus.src)
	);

	// Bus decode: only index bits 9 to 2 are decoded; bits 31 to 10 must be zero.
	assign acc    = hsel && htrans == HTRANS_NONSEQ && hready;
	assign idx_ok = haddr[31:10] == 22'h0;
	assign wr_do  = wr_pend && ce;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wr_pend <= 1'b0;
			wr_idx  <= 8'h00;
		end else if (ce) begin
			wr_pend <= acc && hwrite && idx_ok;
			if (acc)
				wr_idx <= haddr[9:2];
		end
	end

	// Reads take one wait state so that a write in the previous data
	// phase is already visible in the returned word.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rd_wait   <= 1'b0;
			rd_idx    <= 8'h00;
			hreadyout <= 1'b1;
			hresp     <= HRESP_OKAY;
			hrdata    <= 32'h0;
		end else if (ce) begin
			rd_wait   <= acc && !hwrite;
			hreadyout <= !(acc && !hwrite);
			hresp     <= HRESP_OKAY;
			if (acc)
				rd_idx <= idx_ok ? haddr[9:2] : 8'hff;
			if (rd_wait)
				hrdata <= rdata;
		end
	end

	always_comb begin
		rdata = 32'h0;
		for (int g = 0; g < NGRP; g++) begin
			if (rd_idx == gpcp_port_idx(g, IDX_IN))
				rdata[7:0] = smp_bus.smp[g*GRP_W +: GRP_W];
			if (rd_idx == gpcp_port_idx(g, IDX_DIR))
				rdata[7:0] = dir[g*GRP_W +: GRP_W];
			if (rd_idx == gpcp_port_idx(g, IDX_OUT))
				rdata[7:0] = outv[g*GRP_W +: GRP_W];
			if (rd_idx == IDX_MASK[g])
				rdata[7:0] = mask[g*GRP_W +: GRP_W];
		end
		if (rd_idx == IDX_MCU)
			rdata[PUD_BIT] = global_pullup_disable;
		if (rd_idx == IDX_GFLAG)
			rdata[NGRP-1:0] = gflag;
		if (rd_idx == IDX_GEN)
			rdata[NGRP-1:0] = gen;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			global_pullup_disable <= RST_PUD;
			gen <= '0;
		end else if (wr_do) begin
			if (wr_idx == IDX_MCU)
				global_pullup_disable <= hwdata[PUD_BIT];
			if (wr_idx == IDX_GEN)
				gen <= hwdata[NGRP-1:0];
		end
	end

	genvar g;
	generate
		for (g = 0; g < NGRP; g++) begin : g_grp
			// Each port has its own registers, so a write to one port never
			// disturbs another, and the input toggle flips single bits.
			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					dir[g*GRP_W +: GRP_W]  <= RST_DIR;
					outv[g*GRP_W +: GRP_W] <= RST_OUT;
					mask[g*GRP_W +: GRP_W] <= RST_MASK;
				end else if (wr_do) begin
					if (wr_idx == gpcp_port_idx(g, IDX_DIR))
						dir[g*GRP_W +: GRP_W] <= hwdata[7:0];
					if (wr_idx == gpcp_port_idx(g, IDX_OUT))
						outv[g*GRP_W +: GRP_W] <= hwdata[7:0];
					if (wr_idx == gpcp_port_idx(g, IDX_IN))
						outv[g*GRP_W +: GRP_W] <=
							outv[g*GRP_W +: GRP_W] ^ hwdata[7:0];
					if (wr_idx == IDX_MASK[g])
						mask[g*GRP_W +: GRP_W] <= hwdata[7:0];
				end
			end

			assign gset[g] = gen[g] &&
				|(smp_bus.chg[g*GRP_W +: GRP_W] & mask[g*GRP_W +: GRP_W]);
			assign gclr[g] = isr_enter[g] ||
				(wr_do && wr_idx == IDX_GFLAG && hwdata[g]);

			// A change in the same cycle as a clear still leaves the flag set.
			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n)
					gflag[g] <= 1'b0;
				else if (ce)
					gflag[g] <= gset[g] || (gflag[g] && !gclr[g]);
			end
		end
	endgenerate

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			irq_request <= '0;
		else if (ce)
			irq_request <= gflag & gen & {NGRP{global_irq_enable}};
	end

	// Reset clears the enables asynchronously, so pins float with no clock.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pin_oe     <= '0;
			pin_out    <= '0;
			pin_pullup <= '0;
		end else if (ce) begin
			pin_oe     <= (alt_en & alt_oe) | (~alt_en & dir);
			pin_out    <= (alt_en & alt_out) | (~alt_en & outv);
			pin_pullup <= ~alt_en & ~dir & outv & {NP{!global_pullup_disable}};
		end
	end

	// Group 0, and for the flag-set checks also the top group, stand for all groups, whose logic is alike.
	a_flag_set_g0: assert property (
		@(posedge clk) disable iff (!reset_n)
		(ce && gset[0]) |=> gflag[0])
		else $error("group 0 flag not set by change");
	a_flag_set_top: assert property (
		@(posedge clk) disable iff (!reset_n)
		(ce && gset[NGRP-1]) |=> gflag[NGRP-1])
		else $error("top group flag not set by change");
	a_flag_holds: assert property (
		@(posedge clk) disable iff (!reset_n)
		(ce && gflag[0] && !gclr[0]) |=> gflag[0])
		else $error("flag dropped without a clear");
	a_irq_gated: assert property (
		@(posedge clk) disable iff (!reset_n)
		(ce && !(gflag[0] && gen[0] && global_irq_enable))
		|=> !irq_request[0])
		else $error("request raised without all enables");
	a_irq_raised: assert property (
		@(posedge clk) disable iff (!reset_n)
		(ce && gflag[0] && gen[0] && global_irq_enable)
		|=> irq_request[0])
		else $error("request missing with all enables set");
	a_gie_blocks: assert property (
		@(posedge clk) disable iff (!reset_n)
		(ce && !global_irq_enable) |=> irq_request == '0)
		else $error("request raised with global enable off");
	a_isr_clears: assert property (
		@(posedge clk) disable iff (!reset_n)
		(ce && isr_enter[0] && !gset[0]) |=> !gflag[0])
		else $error("service entry did not clear flag");
	a_w0_keeps: assert property (
		@(posedge clk) disable iff (!reset_n)
		(wr_do && wr_idx == IDX_GFLAG && !hwdata[0] && gflag[0]
		&& !isr_enter[0]) |=> gflag[0])
		else $error("writing zero cleared a flag");
	a_w1_clears: assert property (
		@(posedge clk) disable iff (!reset_n)
		(wr_do && wr_idx == IDX_GFLAG && hwdata[0] && !gset[0])
		|=> !gflag[0])
		else $error("writing one did not clear a flag");
	a_gen_blocks: assert property (
		@(posedge clk) disable iff (!reset_n)
		(ce && !gen[0] && !gflag[0]) |=> !gflag[0])
		else $error("flag set with group disabled");
	a_mask_blocks: assert property (
		@(posedge clk) disable iff (!reset_n)
		(ce && mask[GRP_W-1:0] == '0 && !gflag[0]) |=> !gflag[0])
		else $error("flag set with every pin masked");
	a_out_keeps_dir: assert property (
		@(posedge clk) disable iff (!reset_n)
		(wr_do && wr_idx == gpcp_port_idx(0, IDX_OUT))
		|=> dir[7:0] == $past(dir[7:0]))
		else $error("value write disturbed direction");
	a_in_readonly: assert property (
		@(posedge clk) disable iff (!reset_n)
		(wr_do && wr_idx == gpcp_port_idx(0, IDX_IN))
		|=> dir[7:0] == $past(dir[7:0]))
		else $error("input write disturbed direction");
	a_toggle_out: assert property (
		@(posedge clk) disable iff (!reset_n)
		(wr_do && wr_idx == gpcp_port_idx(0, IDX_IN))
		|=> outv[7:0] == ($past(outv[7:0]) ^ $past(hwdata[7:0])))
		else $error("input write did not toggle value");
	a_pud_off: assert property (
		@(posedge clk) disable iff (!reset_n)
		(ce && global_pullup_disable) |=> pin_pullup == '0)
		else $error("pull-up on while disabled");
	a_input_hiz: assert property (
		@(posedge clk) disable iff (!reset_n)
		(ce && !alt_en[0] && !dir[0]) |=> !pin_oe[0])
		else $error("input pin is driven");
	a_pull_cond: assert property (
		@(posedge clk) disable iff (!reset_n)
		(ce && (dir[0] || !outv[0])) |=> !pin_pullup[0])
		else $error("pull-up on for output or value zero");
	a_pull_on: assert property (
		@(posedge clk) disable iff (!reset_n)
		(ce && !alt_en[0] && !dir[0] && outv[0] && !global_pullup_disable)
		|=> pin_pullup[0])
		else $error("pull-up off for input with value one");
	a_drive_out: assert property (
		@(posedge clk) disable iff (!reset_n)
		(ce && !alt_en[0] && dir[0])
		|=> pin_oe[0] && pin_out[0] == $past(outv[0]))
		else $error("output pin not driven to its value");
	a_reset_hiz: assert property (
		@(posedge clk)
		!reset_n |-> pin_oe == '0)
		else $error("pin driven during reset");
	a_alt_isolate: assert property (
		@(posedge clk) disable iff (!reset_n)
		(ce && alt_en[1] && !alt_en[0] && !dir[0]) |=> !pin_oe[0])
		else $error("alternate pin disturbed its neighbour");
	a_alt_drive: assert property (
		@(posedge clk) disable iff (!reset_n)
		(ce && alt_en[1])
		|=> pin_oe[1] == $past(alt_oe[1]))
		else $error("alternate drive enable not applied");
	a_read_wait: assert property (
		@(posedge clk) disable iff (!reset_n)
		(ce && acc && !hwrite) ##1 ce |=> hreadyout)
		else $error("read wait state longer than one cycle");
	a_write_nowait: assert property (
		@(posedge clk) disable iff (!reset_n)
		(ce && acc && hwrite) |=> hreadyout)
		else $error("write inserted a wait state");

	c_flag_irq: cover property (@(posedge clk) disable iff (!reset_n)
		gset[0] ##[1:4] irq_request[0]);
	c_toggle: cover property (@(posedge clk) disable iff (!reset_n)
		wr_do && wr_idx == gpcp_port_idx(0, IDX_IN));
	c_set_clear: cover property (@(posedge clk) disable iff (!reset_n)
		gset[0] && gclr[0]);
	c_pullup: cover property (@(posedge clk) disable iff (!reset_n)
		pin_pullup[0]);
	c_read: cover property (@(posedge clk) disable iff (!reset_n)
		rd_wait ##1 hreadyout);
endmodule : gpcp_port

/* File: gpcp_pins.sv */
`timescale 1ns/1ns
module gpcp_pins (
	// Clock.
	input  wire logic        clk,
	// Port drive.
	input  wire logic [31:0] pin_out,
	input  wire logic [31:0] pin_oe,
	input  wire logic [31:0] pin_pullup,
	// Far-side drive.
	input  wire logic [31:0] ext_en,
	input  wire logic [31:0] ext_val,
	output logic      [31:0] pin_in
);
	logic [31:0] flt = '0;

	// A floating pin keeps changing, so a stale level never passes.
	always @(posedge clk) flt <= ~flt;
	always_comb pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
		| (~pin_oe & ~ext_en & (pin_pullup | flt));
endmodule : gpcp_pins

/* File: gpcp_port_bench.sv */
`timescale 1ns/1ns
module gpcp_port_bench;
	import gpcp_pkg::*;
	logic        clk = 1'b0, reset_n, hsel = 1'b0, hwrite = 1'b0;
	logic        gie = 1'b1, ce = 1'b1, hreadyout, hresp, rd_ph = 1'b0;
	logic [1:0]  htrans = 2'b00;
	logic [3:0]  isr = '0, irq;
	logic [31:0] haddr = '0, hwdata = '0, hrdata, pin_in, pin_out, pin_oe;
	logic [31:0] pin_pu, alt_en = '0, alt_out = '0, alt_oe = '0;
	logic [31:0] ext_en = '1, ext_val = '0, exp_q[$];
	logic [7:0]  m, pb;
	int          error_cnt = 0, check_count = 0, b, u;

	gpcp_port #(.NGRP(4)) i_gpcp_port (.clk(clk), .reset_n(reset_n),
		.ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .global_irq_enable(gie), .isr_enter(isr),
		.irq_request(irq), .alt_en(alt_en), .alt_out(alt_out),
		.alt_oe(alt_oe), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe(pin_oe), .pin_pullup(pin_pu));
	gpcp_pins i_gpcp_pins (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
		.pin_pullup(pin_pu), .ext_en(ext_en), .ext_val(ext_val),
		.pin_in(pin_in));

	always #4 clk = ~clk;

	task chk(string n, logic [31:0] e, logic [31:0] g);
		check_count++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	// Reads complete in the data phase; the oldest note is the answer.
	always @(posedge clk) begin
		if (rd_ph && hreadyout === 1'b1) begin
			chk("hrdata", exp_q.pop_front(), hrdata);
			chk("hresp", 32'(HRESP_OKAY), 32'(hresp));
		end
		if (hreadyout === 1'b1)
			rd_ph <= hsel && htrans == HTRANS_NONSEQ && !hwrite;
	end

	task cy(int n);
		repeat (n) @(posedge clk);
	endtask : cy
	task rdy;
		do @(posedge clk); while (hreadyout !== 1'b1);
	endtask : rdy
	task aph(logic [7:0] i, logic w);
		hsel <= 1'b1;
		haddr <= {22'h0, i, 2'b00};
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		rdy();
		htrans <= 2'b00;
	endtask : aph
	task wr(logic [7:0] i, logic [7:0] d);
		aph(i, 1'b1);
		hwdata <= {24'h0, d};
		rdy();
	endtask : wr
	task rd(logic [7:0] i, logic [7:0] e);
		exp_q.push_back({24'h0, e});
		aph(i, 1'b0);
		rdy();
	endtask : rd
	task tog(int p);
		ext_val[p] <= ~ext_val[p];
		cy(4);
	endtask : tog

	task print_verdict;
		if (error_cnt == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : print_verdict

	initial begin
		#30000;
		error_cnt++;
		print_verdict();
	end

	initial begin
		void'($urandom(55));
		reset_n <= 1'b0;
		ext_val <= $urandom;
		#1 chk("oe_rst", 32'h0, pin_oe);
		cy(4);
		reset_n <= 1'b1;
		for (int g = 0; g < 4; g++) begin
			pb = IDX_PORT_BASE + 8'(3 * g);
			rd(pb + IDX_DIR, RST_DIR);
			rd(pb + IDX_OUT, RST_OUT);
			rd(IDX_MASK[g], RST_MASK);
			rd(pb + IDX_IN, ext_val[8*g+:8]);
		end
		rd(8'h10, 8'h00);
		for (int g = 0; g < 4; g++) begin
			b = $urandom_range(7, 0);
			u = (b + 1) % 8;
			m = (8'($urandom) | (8'h1 << b)) & ~(8'h1 << u);
			wr(IDX_MASK[g], m);
			wr(IDX_GEN, 8'h1 << g);
			tog(8 * g + u);
			rd(IDX_GFLAG, 8'h0);
			tog(8 * g + b);
			rd(IDX_GFLAG, 8'h1 << g);
			chk("irq", 32'(4'h1 << g), 32'(irq));
			gie <= 1'b0;
			cy(3);
			chk("irq_off", 32'h0, 32'(irq));
			gie <= 1'b1;
			wr(IDX_GFLAG, 8'h0);
			rd(IDX_GFLAG, 8'h1 << g);
			wr(IDX_GFLAG, 8'h1 << g);
			rd(IDX_GFLAG, 8'h0);
			tog(8 * g + b);
			isr <= 4'h1 << g;
			cy(1);
			isr <= '0;
			rd(IDX_GFLAG, 8'h0);
		end
		wr(IDX_GEN, 8'h0);
		// Value first, so high pins pass through pull-up on the way.
		wr(IDX_PORT_BASE + IDX_OUT, 8'h5a);
		wr(IDX_PORT_BASE + IDX_DIR, 8'hff);
		cy(2);
		chk("oe", 32'hff, pin_oe);
		chk("out", 32'h5a, {24'h0, pin_out[7:0]});
		wr(IDX_PORT_BASE + IDX_DIR, 8'hfe);
		cy(2);
		chk("oe_bit", 32'hfe, pin_oe);
		wr(IDX_PORT_BASE + IDX_IN, 8'h0f);
		rd(IDX_PORT_BASE + IDX_OUT, 8'h55);
		cy(3);
		rd(IDX_PORT_BASE + IDX_IN, {7'h2a, ext_val[0]});
		alt_en <= 32'h2;
		alt_oe <= 32'h2;
		alt_out <= 32'h2;
		cy(2);
		chk("alt", 32'h56, {24'h0, pin_out[7:1], 1'b0});
		alt_en <= '0;
		ext_en[15:8] <= 8'h0;
		wr(IDX_PORT_BASE + 8'd3 + IDX_OUT, 8'hff);
		cy(2);
		chk("pu", 32'hff01, pin_pu);
		rd(IDX_PORT_BASE + 8'd3 + IDX_IN, 8'hff);
		wr(IDX_MCU, 8'(1 << PUD_BIT));
		cy(2);
		chk("pud", 32'h0, pin_pu);
		wr(IDX_MCU, 8'h0);
		wr(IDX_PORT_BASE + 8'd3 + IDX_DIR, 8'hff);
		cy(2);
		chk("pu_out", 32'h1, pin_pu);
		// Clock enable low must freeze the pin drive until it returns.
		ce <= 1'b0;
		alt_en <= 32'h1;
		alt_oe <= 32'h1;
		cy(2);
		chk("ce_hold", 32'hfffe, pin_oe);
		ce <= 1'b1;
		cy(2);
		chk("ce_run", 32'hffff, pin_oe);
		print_verdict();
	end
endmodule : gpcp_port_bench
